// ---- verilog/dmb_pkg.sv ----
// dmb_pkg: constants, access carrier and shared decode for the banked data memory
package dmb_pkg;
	// special-function locations served inside this block
	localparam logic [7:0] ADDR_PORT_A     = 8'h00;
	localparam logic [7:0] ADDR_PTR_A      = 8'h01;
	localparam logic [7:0] ADDR_PORT_B     = 8'h02;
	localparam logic [7:0] ADDR_PTR_B      = 8'h03;
	localparam logic [7:0] ADDR_BANK_SEL   = 8'h04;
	// read-only special-function location (table high byte)
	localparam logic [7:0] ADDR_TABLE_HIGH = 8'h08;
	// area boundaries
	localparam logic [7:0] ADDR_SFR_LAST   = 8'h7f;
	localparam logic [7:0] ADDR_GP_FIRST   = 8'h80;
	localparam logic [7:0] ADDR_LCD_LAST   = 8'hcf;
	// bank numbers
	localparam logic [4:0] BANK_ZERO       = 5'h00;
	localparam logic [4:0] BANK_LCD_A      = 5'h01;
	localparam logic [4:0] BANK_LCD_B      = 5'h02;
	localparam logic [4:0] GP_BANK_OFFSET  = 5'h02;
	// bank_select field positions
	localparam int         BANK_DATA_MSB   = 4;
	localparam int         BANK_PROG_LSB   = 5;
	localparam int         BANK_PROG_MSB   = 7;
	// reset values
	localparam logic [7:0] RST_PTR         = 8'h00;
	localparam logic [7:0] RST_BANK        = 8'h00;
	localparam logic [7:0] READ_ZERO       = 8'h00;
	// storage shapes: bank 0 plus banks 3..31 of 128 bytes, two display banks of 80 bytes
	localparam int         GP_DEPTH        = 3840;
	localparam int         GP_AW           = 12;
	localparam int         LCD_DEPTH       = 160;
	localparam int         LCD_AW          = 8;
	localparam logic [7:0] LCD_BANK_BYTES  = 8'h50;
	localparam int         RD_LATENCY      = 2;

	// where a decoded access lands
	typedef enum logic [4:0] {
		TGT_NONE = 5'b00001,
		TGT_INT  = 5'b00010,
		TGT_SFR  = 5'b00100,
		TGT_GP   = 5'b01000,
		TGT_LCD  = 5'b10000
	} dmb_target_t;

	// one data memory access: read, byte write or single-bit set/clear
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic       bitSet;
		logic       bitClr;
		logic [2:0] bitIdx;
		logic [7:0] addr;
		logic [7:0] wdata;
	} dmb_acc_t;

	// new byte value produced by a write or a bit operation on old
	function automatic logic [7:0] dmbModify(input dmb_acc_t a, input logic [7:0] old);
		logic [7:0] mask;
		mask = 8'h01 << a.bitIdx;
		if (a.wr)
			return a.wdata;
		else if (a.bitSet)
			return old | mask;
		else if (a.bitClr)
			return old & ~mask;
		return old;
	endfunction : dmbModify

	// true for any access that changes storage
	function automatic logic dmbIsWrite(input dmb_acc_t a);
		return a.wr | a.bitSet | a.bitClr;
	endfunction : dmbIsWrite

	// protected special-function locations
	function automatic logic dmbIsReadOnly(input logic [7:0] addr);
		return addr == ADDR_TABLE_HIGH;
	endfunction : dmbIsReadOnly
endpackage : dmb_pkg

// ---- verilog/dmb_byte_ram.sv ----
// dmb_byte_ram: byte-wide storage with bit-level modify and a second read port
`timescale 1ns/100ps
`default_nettype none
module dmb_byte_ram #(
	parameter int DEPTH = 16,
	parameter int AW    = 4
) (
	input  wire logic             clk_sys,
	input  wire logic             rst_n,
	input  wire logic             we,
	input  wire logic [AW-1:0]    wrIdx,
	input  wire dmb_pkg::dmb_acc_t acc,
	input  wire logic [AW-1:0]    rdIdx,
	output logic      [7:0]       rdData,
	input  wire logic [AW-1:0]    dispIdx,
	output logic      [7:0]       dispData
);
	import dmb_pkg::*;

	logic [7:0] mem [DEPTH];
	logic [7:0] wrByte;
	logic [7:0] rdData_nxt;
	logic [7:0] dispData_nxt;

	// every location is one byte; bit ops touch only the addressed bit
	always_comb begin
		wrByte       = dmbModify(acc, mem[wrIdx]);
		rdData_nxt   = rst_n ? mem[rdIdx] : READ_ZERO;
		dispData_nxt = rst_n ? mem[dispIdx] : READ_ZERO;
	end

	// contents are volatile and carry no reset, only the read latches do
	always_ff @(posedge clk_sys) begin
		if (we)
			mem[wrIdx] <= wrByte;
		rdData   <= rdData_nxt;
		dispData <= dispData_nxt;
	end
endmodule : dmb_byte_ram
`default_nettype wire

// ---- verilog/dmb_data_memory.sv ----
// dmb_data_memory: bank decode, pointers, bank select and storage of the data memory
//
// Behaviour
// - every data memory location in every bank is one volatile byte
// - special-function area 00h..7fh is the same in every bank
// - bank zero holds general RAM at 80h..ffh above the special area
// - banks one and two hold display RAM at 80h..cfh
// - banks three to thirty-one hold general RAM at 80h..ffh
// - port b bank choice follows the current bank select value
// - unused special-function reads may return any value
// - display RAM only via second pointer pair with bank one or two
// - bank one or two below 80h reaches the common special registers
// - bank one or two above display range reads zero
// - display RAM contents feed the display driver directly
// - protected special registers ignore writes but still read back
// - single-bit set and clear change only the chosen bit
// - ports act on paired pointer; port a bank zero, b any; port-on-port is null
// - direct addressing always lands in bank zero
// - reset selects bank zero unless watchdog reset in power-down
// - bank select low five bits pick data bank, top three program bank
`timescale 1ns/100ps
`default_nettype none
module dmb_data_memory (
	input  wire logic              clk_sys,
	input  wire logic              rst_n,
	input  wire dmb_pkg::dmb_acc_t cpuReq,
	input  wire logic              wdtPdReset,
	output logic      [7:0]        rdData,
	output logic                   rdValid,
	output dmb_pkg::dmb_acc_t      sfrReq,
	input  wire logic [7:0]        sfrRdata,
	output logic      [2:0]        progBank,
	input  wire logic [7:0]        lcdIdx,
	output logic      [7:0]        lcdData
);
	import dmb_pkg::*;

	logic        [7:0]       ptrA_r;
	logic        [7:0]       ptrA_nxt;
	logic        [7:0]       ptrB_r;
	logic        [7:0]       ptrB_nxt;
	logic        [7:0]       bankSel_r;
	logic        [7:0]       bankSel_nxt;
	logic                    isIndA;
	logic                    isIndB;
	logic                    isNull;
	logic                    isAccess;
	logic                    isWr;
	logic        [7:0]       effAddr;
	logic        [4:0]       effBank;
	logic        [4:0]       gpBank;
	logic        [GP_AW-1:0] gpIdx;
	logic        [7:0]       lcdIdxCpu;
	dmb_target_t             tgt;
	dmb_target_t             tgt_r;
	dmb_target_t             tgt_nxt;
	logic                    rdPend_r;
	logic                    rdPend_nxt;
	logic        [7:0]       intVal_r;
	logic        [7:0]       intVal;
	logic        [7:0]       intVal_nxt;
	dmb_acc_t                sfrReq_r;
	dmb_acc_t                sfrReq_nxt;
	logic        [7:0]       rdData_r;
	logic        [7:0]       rdData_nxt;
	logic                    rdValid_r;
	logic                    rdValid_nxt;
	logic                    gpWe;
	logic                    lcdWe;
	logic        [7:0]       gpRd;
	logic        [7:0]       lcdRd;

	// resolve the indirect ports to their pointers; only port b honours the bank
	always_comb begin
		isIndA   = cpuReq.addr == ADDR_PORT_A;
		isIndB   = cpuReq.addr == ADDR_PORT_B;
		isAccess = cpuReq.rd | dmbIsWrite(cpuReq);
		isWr     = dmbIsWrite(cpuReq);
		if (isIndA)
			effAddr = ptrA_r;
		else if (isIndB)
			effAddr = ptrB_r;
		else
			effAddr = cpuReq.addr;
		// direct and port-a accesses never leave bank zero
		effBank = isIndB ? bankSel_r[BANK_DATA_MSB:0] : BANK_ZERO;
		// a pointer naming a port would recurse; such an access becomes a no-op instead
		isNull  = (isIndA | isIndB) &&
			(effAddr == ADDR_PORT_A || effAddr == ADDR_PORT_B);
	end

	// area decode: the special area ignores the bank, the upper half depends on it
	always_comb begin
		tgt = TGT_NONE;
		if (!isAccess || isNull)
			tgt = TGT_NONE;
		else if (effAddr <= ADDR_SFR_LAST) begin
			// common area for every bank, bank one and two included
			if (effAddr == ADDR_PTR_A || effAddr == ADDR_PTR_B || effAddr == ADDR_BANK_SEL)
				tgt = TGT_INT;
			else
				tgt = TGT_SFR;
		end else if (effBank == BANK_LCD_A || effBank == BANK_LCD_B) begin
			// only port b can carry a nonzero bank here, so direct access never hits it
			tgt = (effAddr <= ADDR_LCD_LAST) ? TGT_LCD : TGT_NONE;
		end else
			tgt = TGT_GP;
	end

	// storage indices: bank zero at 0, bank n (n>=3) at (n-2)*128
	always_comb begin
		// banks one and two own no general storage, so the index skips over them
		gpBank    = (effBank == BANK_ZERO) ? BANK_ZERO : effBank - GP_BANK_OFFSET;
		gpIdx     = {gpBank, effAddr[6:0]};
		lcdIdxCpu = {1'b0, effAddr[6:0]} +
			((effBank == BANK_LCD_B) ? LCD_BANK_BYTES : READ_ZERO);
		// anything decoded as none is simply not written
		gpWe      = isWr && tgt == TGT_GP;
		lcdWe     = isWr && tgt == TGT_LCD;
	end

	// value of the addressed in-block register, used for reads; bit ops modify the registers directly
	always_comb begin
		case (effAddr)
			ADDR_PTR_A:    intVal = ptrA_r;
			ADDR_PTR_B:    intVal = ptrB_r;
			ADDR_BANK_SEL: intVal = bankSel_r;
			default:       intVal = READ_ZERO;
		endcase
	end

	// pointer and bank select next values; a watchdog power-down reset keeps the bank
	always_comb begin
		ptrA_nxt    = ptrA_r;
		ptrB_nxt    = ptrB_r;
		bankSel_nxt = bankSel_r;
		if (!rst_n) begin
			ptrA_nxt    = RST_PTR;
			ptrB_nxt    = RST_PTR;
			bankSel_nxt = wdtPdReset ? bankSel_r : RST_BANK;
		end else if (isWr && tgt == TGT_INT) begin
			case (effAddr)
				ADDR_PTR_A:    ptrA_nxt    = dmbModify(cpuReq, ptrA_r);
				ADDR_PTR_B:    ptrB_nxt    = dmbModify(cpuReq, ptrB_r);
				ADDR_BANK_SEL: bankSel_nxt = dmbModify(cpuReq, bankSel_r);
				default:       bankSel_nxt = bankSel_r;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		ptrA_r    <= ptrA_nxt;
		ptrB_r    <= ptrB_nxt;
		bankSel_r <= bankSel_nxt;
	end

	// outgoing special-function access; protected locations see reads only
	always_comb begin
		sfrReq_nxt = '0;
		if (rst_n && tgt == TGT_SFR) begin
			sfrReq_nxt      = cpuReq;
			sfrReq_nxt.addr = effAddr;
			if (dmbIsReadOnly(effAddr)) begin
				sfrReq_nxt.wr     = 1'b0;
				sfrReq_nxt.bitSet = 1'b0;
				sfrReq_nxt.bitClr = 1'b0;
			end
		end
	end

	// read pipeline: stage one latches the decode, stage two picks the byte
	always_comb begin
		case (tgt_r)
			TGT_INT: rdData_nxt = intVal_r;
			TGT_SFR: rdData_nxt = sfrRdata;
			TGT_GP:  rdData_nxt = gpRd;
			TGT_LCD: rdData_nxt = lcdRd;
			default: rdData_nxt = READ_ZERO;
		endcase
		if (!rdPend_r)
			rdData_nxt = rdData_r;
		if (!rst_n)
			rdData_nxt = READ_ZERO;
	end

	// stage one next values; reset empties the pipe so no stale answer leaves it
	always_comb begin
		tgt_nxt     = tgt;
		rdPend_nxt  = cpuReq.rd;
		intVal_nxt  = intVal;
		rdValid_nxt = rdPend_r;
		if (!rst_n) begin
			tgt_nxt     = TGT_NONE;
			rdPend_nxt  = 1'b0;
			intVal_nxt  = READ_ZERO;
			rdValid_nxt = 1'b0;
		end
	end

	// the special-function peripheral answers combinationally in the cycle after
	always_ff @(posedge clk_sys) begin
		tgt_r     <= tgt_nxt;
		rdPend_r  <= rdPend_nxt;
		intVal_r  <= intVal_nxt;
		sfrReq_r  <= sfrReq_nxt;
		rdData_r  <= rdData_nxt;
		rdValid_r <= rdValid_nxt;
	end

	assign rdData   = rdData_r;
	assign rdValid  = rdValid_r;
	assign sfrReq   = sfrReq_r;
	assign progBank = bankSel_r[BANK_PROG_MSB:BANK_PROG_LSB];

	// general RAM for bank zero and banks three to thirty-one
	dmb_byte_ram #(
		.DEPTH (GP_DEPTH),
		.AW    (GP_AW)
	) u_gp_ram (
		.clk_sys  (clk_sys),
		.rst_n    (rst_n),
		.we       (gpWe),
		.wrIdx    (gpIdx),
		.acc      (cpuReq),
		.rdIdx    (gpIdx),
		.rdData   (gpRd),
		.dispIdx  (gpIdx),
		.dispData ()
	);

	// display RAM; the driver port reads the same array the cpu writes
	dmb_byte_ram #(
		.DEPTH (LCD_DEPTH),
		.AW    (LCD_AW)
	) u_lcd_ram (
		.clk_sys  (clk_sys),
		.rst_n    (rst_n),
		.we       (lcdWe),
		.wrIdx    (lcdIdxCpu),
		.acc      (cpuReq),
		.rdIdx    (lcdIdxCpu),
		.rdData   (lcdRd),
		.dispIdx  (lcdIdx),
		.dispData (lcdData)
	);

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	a_read_latency: assert property (cpuReq.rd |-> ##2 rdValid_r)
		else $error("read answer not two cycles after request");
	a_bank_reset: assert property (disable iff (1'b0)
		(!rst_n && !wdtPdReset) |=> bankSel_r == RST_BANK)
		else $error("reset did not return to bank zero");
	a_bank_keep: assert property (disable iff (1'b0)
		(!rst_n && wdtPdReset) |=> $stable(bankSel_r))
		else $error("watchdog power-down reset changed the bank");
	a_bank_write: assert property ((cpuReq.wr && cpuReq.addr == ADDR_BANK_SEL)
		|=> bankSel_r == $past(cpuReq.wdata))
		else $error("bank select write not taken");
	a_sfr_common: assert property ((cpuReq.rd && isIndB && tgt == TGT_SFR)
		|=> sfrReq_r.rd && sfrReq_r.addr == $past(ptrB_r))
		else $error("common special area not reached through port b");
	a_lcd_gap_zero: assert property ((cpuReq.rd && isIndB && effAddr > ADDR_LCD_LAST &&
		(effBank == BANK_LCD_A || effBank == BANK_LCD_B)) |-> ##2 rdData_r == READ_ZERO)
		else $error("display bank gap did not read zero");
	a_port_null: assert property ((cpuReq.rd && isNull) |-> ##2 rdData_r == READ_ZERO)
		else $error("port on port read not zero");
	a_ro_protect: assert property ((isWr && tgt == TGT_SFR && dmbIsReadOnly(effAddr))
		|=> !sfrReq_r.wr && !sfrReq_r.bitSet && !sfrReq_r.bitClr && sfrReq_r.addr == ADDR_TABLE_HIGH)
		else $error("write reached a protected register");
	a_lcd_path: assert property (lcdWe |-> isIndB &&
		(bankSel_r[BANK_DATA_MSB:0] == BANK_LCD_A || bankSel_r[BANK_DATA_MSB:0] == BANK_LCD_B))
		else $error("display RAM written outside port b");
	a_direct_bank0: assert property ((cpuReq.rd && !isIndA && !isIndB &&
		cpuReq.addr >= ADDR_GP_FIRST) |-> gpIdx[GP_AW-1:7] == BANK_ZERO && tgt == TGT_GP)
		else $error("direct access left bank zero");

	// indirect mapping checks: dropped writes, port a, high banks, forwarded writes
	// these watch the decode itself, the bench model watches the resulting bytes
	a_null_write: assert property ((isWr && isNull)
		|=> $stable(ptrA_r) && $stable(ptrB_r) && $stable(bankSel_r) && !sfrReq_r.wr)
		else $error("port on port write changed state");
	a_port_a_bank0: assert property ((isAccess && isIndA && ptrA_r >= ADDR_GP_FIRST)
		|-> tgt == TGT_GP && gpIdx[GP_AW-1:7] == BANK_ZERO)
		else $error("port a left bank zero");
	a_gp_bank_map: assert property ((isAccess && isIndB && ptrB_r >= ADDR_GP_FIRST &&
		bankSel_r[BANK_DATA_MSB:0] > BANK_LCD_B) |-> tgt == TGT_GP &&
		gpIdx[GP_AW-1:7] + GP_BANK_OFFSET == bankSel_r[BANK_DATA_MSB:0])
		else $error("high bank not mapped to its own storage");
	a_sfr_forward: assert property ((isWr && tgt == TGT_SFR && !dmbIsReadOnly(effAddr))
		|=> sfrReq_r.addr == $past(effAddr) &&
		(sfrReq_r.wr || sfrReq_r.bitSet || sfrReq_r.bitClr))
		else $error("special-function write not forwarded");

	c_lcd_write: cover property (lcdWe);
	c_high_bank: cover property (gpWe && gpBank == 5'h1d);
	c_sfr_via_b: cover property (cpuReq.rd && isIndB && tgt == TGT_SFR);
	c_port_null: cover property (isWr && isNull);
	c_bank_keep: cover property (disable iff (1'b0) !rst_n && wdtPdReset);
endmodule : dmb_data_memory
`default_nettype wire

// ---- verification/dmb_cpu_model.sv ----
// dmb_cpu_model: cpu request driver and peripheral registers behind sfrReq
`timescale 1ns/100ps
`default_nettype none
module dmb_cpu_model (
	input  wire logic              clk_sys,
	output var  dmb_pkg::dmb_acc_t cpuReq,
	input  wire dmb_pkg::dmb_acc_t sfrReq,
	output logic [7:0]             sfrRdata
);
	import dmb_pkg::*;
	logic [7:0] regs [128];
	// known start pattern, mirrored by the bench
	initial begin
		cpuReq = '0;
		for (int i = 0; i < 128; i++)
			regs[i] = 8'(i) ^ 8'h5a;
	end
	// answer is combinational, as the forwarded request demands
	assign sfrRdata = regs[sfrReq.addr[6:0]];
	// peripherals apply bit operations themselves
	always @(posedge clk_sys) begin
		if (sfrReq.wr)
			regs[sfrReq.addr[6:0]] <= sfrReq.wdata;
		else if (sfrReq.bitSet)
			regs[sfrReq.addr[6:0]][sfrReq.bitIdx] <= 1'b1;
		else if (sfrReq.bitClr)
			regs[sfrReq.addr[6:0]][sfrReq.bitIdx] <= 1'b0;
	end
	// raised after an edge, held over exactly one taking edge, then one idle edge
	// so that two calls in a row never write cpuReq twice in one time step
	task automatic issue(input dmb_acc_t a);
		cpuReq = a;
		@(posedge clk_sys);
		#1 cpuReq = '0;
		@(posedge clk_sys);
		#1;
	endtask : issue
endmodule : dmb_cpu_model
`default_nettype wire

// ---- verification/dmb_data_memory_bench.sv ----
// dmb_data_memory_bench: reference-model bench for the banked data memory
`timescale 1ns/100ps
`default_nettype none
module dmb_data_memory_bench;
	import dmb_pkg::*;
	localparam logic [3:0] K_RD  = 4'h8;
	localparam logic [3:0] K_WR  = 4'h4;
	localparam logic [3:0] K_SET = 4'h2;
	localparam logic [3:0] K_CLR = 4'h1;
	logic        clk_sys    = 1'b0;
	logic        rst_n      = 1'b0;
	logic        wdtPdReset = 1'b0;
	logic [7:0]  lcdIdx     = 8'h00;
	logic [7:0]  rdData, sfrRdata, lcdData;
	logic        rdValid;
	logic [2:0]  progBank;
	dmb_acc_t    cpuReq, sfrReq;
	// model state: ram by {bank, addr}, peripheral mirror, pointers
	logic [7:0]  mem [8192];
	logic [7:0]  sfr [128];
	logic [7:0]  ptrA, ptrB, bank;
	logic [31:0] seed = 32'd83;
	int          errorCnt = 0;
	int          checked = 0;

	// 8 ns clock
	always #4 clk_sys = ~clk_sys;

	dmb_data_memory dmb_data_memory_i (.clk_sys(clk_sys), .rst_n(rst_n), .cpuReq(cpuReq),
		.wdtPdReset(wdtPdReset), .rdData(rdData), .rdValid(rdValid), .sfrReq(sfrReq),
		.sfrRdata(sfrRdata), .progBank(progBank), .lcdIdx(lcdIdx), .lcdData(lcdData));
	dmb_cpu_model dmb_cpu_model_i (.clk_sys(clk_sys), .cpuReq(cpuReq), .sfrReq(sfrReq),
		.sfrRdata(sfrRdata));

	// xorshift source
	function automatic logic [7:0] rnd8();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction : rnd8

	// never-written ram is unknown in the model, so it is skipped
	task automatic cmpByte(input logic [7:0] got, input logic [7:0] exp);
		if ($isunknown(exp))
			return;
		checked++;
		if (got !== exp) begin
			errorCnt++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask : cmpByte

	// decode one access: expected read byte out, writes applied
	task automatic model(input dmb_acc_t a, output logic [7:0] q);
		logic [7:0] ea;
		logic [7:0] v;
		logic [4:0] bk;
		ea = a.addr;
		bk = BANK_ZERO;
		q = READ_ZERO;
		if (a.addr == ADDR_PORT_A)
			ea = ptrA;
		if (a.addr == ADDR_PORT_B)
			bk = bank[4:0];
		if (a.addr == ADDR_PORT_B)
			ea = ptrB;
		if (a.addr inside {ADDR_PORT_A, ADDR_PORT_B} && ea inside {ADDR_PORT_A, ADDR_PORT_B})
			return;
		if (ea > ADDR_LCD_LAST && bk inside {BANK_LCD_A, BANK_LCD_B})
			return;
		case (ea)
			ADDR_PTR_A: v = ptrA;
			ADDR_PTR_B: v = ptrB;
			ADDR_BANK_SEL: v = bank;
			default: v = ea[7] ? mem[{bk, ea}] : sfr[ea[6:0]];
		endcase
		q = v;
		if (a.wr)
			v = a.wdata;
		else if (a.bitSet)
			v[a.bitIdx] = 1'b1;
		else if (a.bitClr)
			v[a.bitIdx] = 1'b0;
		else
			return;
		case (ea)
			ADDR_PTR_A: ptrA = v;
			ADDR_PTR_B: ptrB = v;
			ADDR_BANK_SEL: bank = v;
			ADDR_TABLE_HIGH: v = q;
			default: begin
				if (ea[7])
					mem[{bk, ea}] = v;
				else
					sfr[ea[6:0]] = v;
			end
		endcase
	endtask : model

	// one access through the cpu model; a read waits for its answer
	task automatic acc(input logic [3:0] k, input logic [7:0] ad, input logic [7:0] wd,
		input logic [2:0] bi);
		dmb_acc_t a;
		logic [7:0] q;
		int n;
		a = {k, bi, ad, wd};
		n = 0;
		model(a, q);
		dmb_cpu_model_i.issue(a);
		if (!a.rd)
			return;
		while (rdValid !== 1'b1 && n < 4) begin
			@(posedge clk_sys);
			#1 n++;
		end
		cmpByte({7'h00, rdValid}, 8'h01);
		cmpByte(rdData, q);
	endtask : acc

	// reset held four cycles; keep marks a watchdog reset in power-down
	task automatic doReset(input logic keep);
		wdtPdReset = keep;
		rst_n = 1'b0;
		repeat (4) @(posedge clk_sys);
		#1 rst_n = 1'b1;
		wdtPdReset = 1'b0;
		ptrA = RST_PTR;
		ptrB = RST_PTR;
		if (!keep)
			bank = RST_BANK;
		// first request only in the cycle after the first edge out of reset
		@(posedge clk_sys);
		#1;
	endtask : doReset

	// display byte shows one cycle after its index
	task automatic lcdCheck(input logic [7:0] i);
		lcdIdx = i;
		@(posedge clk_sys);
		#1 cmpByte(lcdData, mem[{i < 8'd80 ? BANK_LCD_A : BANK_LCD_B,
			i < 8'd80 ? i + 8'h80 : i + 8'h30}]);
	endtask : lcdCheck

	task automatic endOfTest();
		if (errorCnt == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : endOfTest

	// main sequence
	initial begin
		logic [7:0] ad;
		for (int i = 0; i < 128; i++)
			sfr[i] = 8'(i) ^ 8'h5a;
		doReset(1'b0);
		for (int i = 0; i < 5; i++)
			acc(K_RD, 8'(i), 8'h00, 3'h0);
		cmpByte({5'h00, progBank}, 8'h00);
		for (int i = 0; i < 8; i++) begin
			ad = 8'h80 | rnd8();
			acc(K_WR, ad, rnd8(), 3'h0);
			acc(K_SET, ad, 8'h00, 3'(i));
			acc(K_CLR, ad, 8'h00, 3'(7 - i));
			acc(K_RD, ad, 8'h00, 3'h0);
		end
		acc(K_WR, ADDR_TABLE_HIGH, 8'ha5, 3'h0);
		acc(K_RD, ADDR_TABLE_HIGH, 8'h00, 3'h0);
		acc(K_SET, 8'h40, 8'h00, 3'h7);
		acc(K_RD, 8'h7f, 8'h00, 3'h0);
		// every bank via port b (pointer 40h when b % 4 is 1), a bank-zero byte at the same address
		for (int b = 0; b < 32; b++) begin
			ad = 8'h80 | rnd8();
			acc(K_WR, ADDR_BANK_SEL, (rnd8() & 8'he0) | 8'(b), 3'h0);
			acc(K_WR, ADDR_PTR_B, b % 4 == 1 ? 8'h40 : ad, 3'h0);
			cmpByte({5'h00, progBank}, {5'h00, bank[7:5]});
			acc(K_WR, ad, 8'h11, 3'h0);
			acc(K_WR, ADDR_PORT_B, rnd8(), 3'h0);
			acc(K_CLR, ADDR_PORT_B, 8'h00, 3'(b));
			acc(K_RD, ADDR_PORT_B, 8'h00, 3'h0);
			acc(K_RD, ad, 8'h00, 3'h0);
		end
		acc(K_WR, ADDR_PTR_A, 8'h90, 3'h0);
		acc(K_WR, ADDR_PORT_A, 8'h6b, 3'h0);
		acc(K_RD, 8'h90, 8'h00, 3'h0);
		acc(K_SET, ADDR_PTR_A, 8'h00, 3'h0);
		acc(K_RD, ADDR_PTR_A, 8'h00, 3'h0);
		acc(K_WR, ADDR_PTR_B, ADDR_PORT_B, 3'h0);
		acc(K_WR, ADDR_PORT_B, 8'hff, 3'h0);
		acc(K_RD, ADDR_PORT_B, 8'h00, 3'h0);
		// display ends and one byte shadowed by a direct write
		for (int i = 0; i < 6; i++) begin
			acc(K_WR, ADDR_BANK_SEL, 8'(1 + i % 2), 3'h0);
			acc(K_WR, ADDR_PTR_B, i < 2 ? 8'h80 : i < 4 ? 8'hcf : 8'hd7, 3'h0);
			acc(K_WR, ADDR_PORT_B, rnd8(), 3'h0);
			acc(K_RD, ADDR_PORT_B, 8'h00, 3'h0);
		end
		acc(K_WR, 8'h80, 8'h77, 3'h0);
		for (int i = 0; i < 12; i++)
			lcdCheck(i < 4 ? 8'(i / 2 * 80 + i % 2 * 79) : rnd8() % 8'd160);
		acc(K_WR, ADDR_BANK_SEL, 8'h63, 3'h0);
		doReset(1'b1);
		acc(K_RD, ADDR_BANK_SEL, 8'h00, 3'h0);
		cmpByte({5'h00, progBank}, 8'h03);
		doReset(1'b0);
		acc(K_RD, ADDR_BANK_SEL, 8'h00, 3'h0);
		acc(K_RD, 8'h90, 8'h00, 3'h0);
		endOfTest();
	end

	// cut a hang short long after the tests should be done
	initial begin
		#100000;
		errorCnt++;
		$display("MISMATCH %0t watchdog expired", $time);
		endOfTest();
	end
endmodule : dmb_data_memory_bench
`default_nettype wire
